// >>> common/uts_pkg.sv
// shared constants and types for the tag state and flag core
`default_nettype none
package uts_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned RETAIN_TIME_MS = 4_000;
  localparam int unsigned RETAIN_CYCLES =
    RETAIN_TIME_MS * (CLK_HZ / 1_000);
  localparam int unsigned RET_CNT_W     = 26;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned MEM_BYTES     = 256;
  localparam int unsigned QUAD_BYTES    = 4;

  localparam logic [7:0] REG_FLAGS = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_CTRL  = 8'h08;
  localparam int unsigned CTRL_SEALED_BIT = 0;
  localparam int unsigned CTRL_CLRLOCK_BIT = 1;

  localparam int unsigned FLAG_XCHG  = 0;
  localparam int unsigned FLAG_WROK  = 1;
  localparam int unsigned FLAG_BPRES = 2;
  localparam int unsigned FLAG_BGOOD = 3;

  typedef enum logic [1:0] {
    ST_POWER_OFF     = 2'b00,
    ST_READY         = 2'b01,
    ST_IDENTIFY      = 2'b11,
    ST_DATA_EXCHANGE = 2'b10
  } uts_state_t;

  typedef enum logic [5:0] {
    CMD_PICK_EQ    = 6'h00, CMD_PICK_NE    = 6'h01,
    CMD_PICK_GT    = 6'h02, CMD_PICK_LT    = 6'h03,
    CMD_PICK_EQF   = 6'h04, CMD_PICK_NEF   = 6'h05,
    CMD_DROP_EQ    = 6'h06, CMD_DROP_NE    = 6'h07,
    CMD_DROP_GT    = 6'h08, CMD_DROP_LT    = 6'h09,
    CMD_DROP_EQF   = 6'h0A, CMD_DROP_NEF   = 6'h0B,
    CMD_MULTI_DROP = 6'h0C, CMD_FAIL       = 6'h0D,
    CMD_SUCCESS    = 6'h0E, CMD_REPEAT     = 6'h0F,
    CMD_REINIT     = 6'h10, CMD_READ       = 6'h11,
    CMD_DATA_READ  = 6'h12, CMD_READ_VFY   = 6'h13,
    CMD_READ_VFY4  = 6'h14, CMD_STORE      = 6'h15,
    CMD_QUAD_STORE = 6'h16, CMD_QUAD_MULTI = 6'h17,
    CMD_STORE_MULTI = 6'h18, CMD_PROTECT   = 6'h19,
    CMD_PROTECT_QRY = 6'h1A, CMD_FAIL_ALT  = 6'h1B,
    CMD_SUCCESS_ALT = 6'h1C, CMD_DREAD_ALT = 6'h1D,
    CMD_FLAG_READ  = 6'h1E, CMD_VAR_READ   = 6'h1F,
    CMD_PORT_READ  = 6'h20, CMD_ANON_FETCH = 6'h21,
    CMD_REPEAT_ALT = 6'h22
  } uts_cmd_e;

  // one decoded command frame from the forward-link front end
  typedef struct packed {
    logic             valid;
    logic             crc_ok;
    uts_cmd_e         code;
    logic             uid_match;
    logic             cond_match;
    logic [ADDR_W-1:0] addr;
    logic [31:0]      data;
  } uts_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uts_resp_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } uts_bus_t;
endpackage
`default_nettype wire

// >>> dv/tb_uhf_tag_state_and_flags.sv
// self-checking bench for the tag state and flag core
`default_nettype none
module tb_uhf_tag_state_and_flags;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RET = 20;
  localparam logic [5:0] ARB [6] = '{6'h0D, 6'h0E, 6'h0F,
                                     6'h1B, 6'h1C, 6'h22};
  logic                clk, reset_n, field_on, energy_ok, battery_good;
  logic                resync_seen, calib_reinit, got;
  logic [31:0]         rdata, w, x;
  logic [7:0]          flags, d, a;
  uts_pkg::uts_bus_t   bus;
  uts_pkg::uts_cmd_t   cmd, f;
  uts_pkg::uts_resp_t  resp;
  uts_pkg::uts_state_t state;
  int                  num_errors, comparisons, seed;

  uts_core #(.RETAIN_CYCLES(RET), .BATTERY_FITTED(1'b1)) u_uts_core (
    .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .cmd(cmd),
    .resp(resp), .field_on(field_on), .energy_ok(energy_ok),
    .battery_good(battery_good), .resync_seen(resync_seen),
    .calib_reinit(calib_reinit), .flags(flags), .state(state));
  uts_reader #(.WAIT_CYC(40)) u_uts_reader (.clk(clk), .resp(resp),
    .cmd(cmd), .resync_seen(resync_seen));

  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (e !== g) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic uts_pkg::uts_cmd_t fr(input logic [5:0] c,
      input logic u, k, input logic [7:0] ad, input logic [31:0] v);
    fr = '{1'b1, 1'b1, uts_pkg::uts_cmd_e'(c), u, k, ad, v};
  endfunction
  function automatic bit legal(input logic [5:0] c,
      input uts_pkg::uts_state_t s);
    bit arb;
    arb = c <= 6'h0F || c inside {6'h1B, 6'h1C, 6'h22};
    if (s == uts_pkg::ST_POWER_OFF) return 1'b0;
    if (s == uts_pkg::ST_IDENTIFY) return c != 6'h19;
    if (s == uts_pkg::ST_DATA_EXCHANGE) return !arb;
    return c <= 6'h05 ||
      !(arb || c inside {6'h12, 6'h17, 6'h18, 6'h19, 6'h1D});
  endfunction
  task automatic go(input logic [5:0] c, input logic u, k,
      input logic [7:0] ad, input logic [31:0] v, input logic eg,
      input uts_pkg::uts_state_t es);
    u_uts_reader.send(fr(c, u, k, ad, v), got, d);
    chk("resp valid", eg, got);
    chk("state", es, state);
  endtask
  task automatic sweep(input uts_pkg::uts_state_t s);
    for (int c = 0; c <= 'h22; c++) begin
      w = $random(seed);
      if (!legal(c[5:0], s))
        go(c[5:0], w[0], w[1], w[15:8], w, 1'b0, s);
    end
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, ad, 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, ad, v};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic resync_chk(input int n);
    u_uts_reader.quiet_resync(n);
    @(negedge clk);
    chk("calib", 1'b1, calib_reinit);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(20_000 * 100);
    num_errors++;
    close_out();
  end
  initial begin
    seed = 69;
    num_errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    field_on = 1'b0;
    energy_ok = 1'b0;
    battery_good = 1'b0;
    bus = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("rst flags", 8'h04, flags);
    sweep(uts_pkg::ST_POWER_OFF);
    @(posedge clk);
    field_on <= 1'b1;
    energy_ok <= 1'b1;
    battery_good <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("up", uts_pkg::ST_READY, state);
    chk("bat", 8'h0C, flags);
    wr(uts_pkg::REG_CTRL, 32'h2);
    wr(uts_pkg::REG_FLAGS, 32'hFF);
    rd(uts_pkg::REG_FLAGS, w);
    chk("reg flags", 32'h0C, w);
    rd(8'h40, w);
    chk("unmapped", 32'h0, w);
    @(posedge clk);
    battery_good <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("bat low", 8'h04, flags);
    @(posedge clk);
    battery_good <= 1'b1;
    sweep(uts_pkg::ST_READY);
    f = fr(6'h00, 1'b0, 1'b1, 8'h00, 32'h0);
    f.crc_ok = 1'b0;
    u_uts_reader.send(f, got, d);
    chk("crc", 1'b0, got);
    go(6'h00, 1'b0, 1'b1, 8'h00, 32'h0, 1'b1, uts_pkg::ST_IDENTIFY);
    sweep(uts_pkg::ST_IDENTIFY);
    for (int i = 0; i < 6; i++) begin
      go(ARB[i], 1'b0, 1'b0, 8'h00, 32'h0, 1'b1,
         uts_pkg::ST_IDENTIFY);
      chk("arb data", 8'h0C, d);
    end
    go(6'h06, 1'b0, 1'b1, 8'h00, 32'h0, 1'b0, uts_pkg::ST_READY);
    go(6'h05, 1'b0, 1'b1, 8'h00, 32'h0, 1'b1, uts_pkg::ST_IDENTIFY);
    go(6'h12, 1'b1, 1'b0, 8'h00, 32'h0, 1'b1,
       uts_pkg::ST_DATA_EXCHANGE);
    chk("xchg flag", 8'h0D, flags);
    sweep(uts_pkg::ST_DATA_EXCHANGE);
    w = $random(seed);
    a = w[7:0];
    x = $random(seed);
    go(6'h15, 1'b1, 1'b0, a, x, 1'b1, uts_pkg::ST_DATA_EXCHANGE);
    go(6'h1E, 1'b1, 1'b0, a, x, 1'b0, uts_pkg::ST_DATA_EXCHANGE);
    chk("wr ok", 8'h0F, flags);
    resync_chk(40);
    go(6'h11, 1'b1, 1'b0, a, 32'h0, 1'b1, uts_pkg::ST_DATA_EXCHANGE);
    chk("mem", x[31:24], d);
    chk("wr ok clr", 8'h0D, flags);
    u_uts_reader.send(fr(6'h19, 1'b1, 1'b0, a, 32'h0), got, d);
    chk("lock ok", 8'h0F, flags);
    resync_chk(40);
    go(6'h1A, 1'b1, 1'b0, a, 32'h0, 1'b1, uts_pkg::ST_DATA_EXCHANGE);
    chk("lock bit", 8'h01, d);
    u_uts_reader.send(fr(6'h15, 1'b1, 1'b0, a, ~x), got, d);
    chk("locked wr", 8'h0D, flags);
    resync_chk(40);
    chk("locked ok", 8'h0D, flags);
    wr(uts_pkg::REG_CTRL, 32'h1);
    wr(uts_pkg::REG_CTRL, 32'h2);
    go(6'h11, 1'b1, 1'b0, a, 32'h0, 1'b1, uts_pkg::ST_DATA_EXCHANGE);
    chk("kept", x[31:24], d);
    go(6'h1A, 1'b1, 1'b0, a, 32'h0, 1'b1, uts_pkg::ST_DATA_EXCHANGE);
    chk("sealed", 8'h01, d);
    go(6'h16, 1'b1, 1'b0, a + 8'h10, x, 1'b1,
       uts_pkg::ST_DATA_EXCHANGE);
    resync_chk(40);
    chk("quad ok", 8'h0F, flags);
    for (int i = 0; i < 4; i++) begin
      go(i == 0 ? 6'h13 : 6'h11, 1'b1, 1'b0, a + 8'h10 + i[7:0], 32'h0,
         1'b1, uts_pkg::ST_DATA_EXCHANGE);
      chk("quad", x[31 - 8 * i -: 8], d);
    end
    go(6'h18, 1'b0, 1'b0, a + 8'h20, w, 1'b0,
       uts_pkg::ST_DATA_EXCHANGE);
    resync_chk(40);
    go(6'h11, 1'b1, 1'b0, a + 8'h20, 32'h0, 1'b1,
       uts_pkg::ST_DATA_EXCHANGE);
    chk("multi", w[31:24], d);
    go(6'h10, 1'b0, 1'b0, a, 32'h0, 1'b0, uts_pkg::ST_READY);
    chk("reinit", 8'h0C, flags);
    resync_chk(259);
    go(6'h21, 1'b0, 1'b0, a, 32'h0, 1'b1, uts_pkg::ST_DATA_EXCHANGE);
    @(posedge clk);
    energy_ok <= 1'b0;
    field_on <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("off", uts_pkg::ST_POWER_OFF, state);
    repeat (RET - 2) @(posedge clk);
    @(negedge clk);
    chk("retain", 1'b1, flags[0]);
    @(negedge clk);
    chk("expire", 1'b0, flags[0]);
    close_out();
  end
endmodule
`default_nettype wire

// >>> dv/uts_reader.sv
// reader-side model: command frames, write wait, hop and resync
`default_nettype none
module uts_reader #(
  parameter int WAIT_CYC = 150_000,
  parameter int HOP_CYC  = 259
) (
  input  wire logic               clk,
  input  wire uts_pkg::uts_resp_t resp,
  output uts_pkg::uts_cmd_t       cmd,
  output logic                    resync_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd = '0;
    resync_seen = 1'b0;
  end
  // one frame, then the answer slot; no hop in between
  task automatic send(input uts_pkg::uts_cmd_t f, output logic got,
                      output logic [7:0] d);
    uts_pkg::uts_cmd_t idle;
    idle = uts_pkg::uts_cmd_t'(~f);
    idle.valid = 1'b0;
    @(posedge clk);
    cmd <= f;
    @(posedge clk);
    cmd <= idle;
    @(negedge clk);
    got = resp.valid;
    d = resp.data;
  endtask
  // plain carrier for n cycles, then a one-cycle resync_seen pulse
  task automatic quiet_resync(input int n);
    repeat (n) @(posedge clk);
    resync_seen <= 1'b1;
    @(posedge clk);
    resync_seen <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> rtl/uts_core.sv
// tag protocol state machine, status flags and memory access core
// How it works
// - resync pattern reinitialises data recovery; spurious edges before it dropped.
// - four flag bits: exchange, write ok, battery fitted, battery good.
// - exchange flag set entering data exchange, held until reinitialise or retention expiry while off.
// - when powered off, exchange flag clears after at least 4 s.
// - reinitialise command clears exchange flag at once.
// - write ok flag set after any successful write, lock included.
// - write ok flag cleared after the next command executes.
// - battery fitted flag fixed by build parameter.
// - battery good only when fitted and battery sufficient.
// - memory is 256 one-byte blocks.
// - one lock bit per byte; lock sets it, query reads it.
// - once sealed, no operation clears a lock bit; the code lets the sealing write also clear them, and reset clears sealed.
// - field on moves tag from powered off to ready.
// - loss of stored energy returns tag to powered off from anywhere.
// - command not valid in current state is ignored silently.
// - per-state acceptance of select, unselect, arbitration, lock, data read.
// - reads, single and quad stores, reinit, queries accepted in all powered states; multi stores not in ready.
// - matching select or addressed read moves tag toward selection.
// - matching unselect or reinitialise returns tag to ready.
// - arbitration keeps identify; matching data read enters data exchange.
// - response only after a correctly decoded accepted command.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`default_nettype none
module uts_core #(
  parameter int unsigned RETAIN_CYCLES  = uts_pkg::RETAIN_CYCLES,
  parameter logic        BATTERY_FITTED = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire uts_pkg::uts_bus_t  bus,
  output logic [31:0]             rdata,
  input  wire uts_pkg::uts_cmd_t  cmd,
  output uts_pkg::uts_resp_t      resp,
  input  wire logic               field_on,
  input  wire logic               energy_ok,
  input  wire logic               battery_good,
  input  wire logic               resync_seen,
  output logic                    calib_reinit,
  output logic [7:0]              flags,
  output uts_pkg::uts_state_t     state
);
  localparam logic [uts_pkg::RET_CNT_W-1:0] RET_LAST =
    uts_pkg::RET_CNT_W'(RETAIN_CYCLES - 1);
  localparam logic [2:0] QUAD = 3'(uts_pkg::QUAD_BYTES);

  typedef struct packed {
    uts_pkg::uts_state_t            st;
    logic                           xchg;
    logic                           wr_ok;
    logic                           bgood;
    logic                           wait_resync;
    logic                           sealed;
    logic                           clr_locks;
    logic [uts_pkg::RET_CNT_W-1:0]  ret_cnt;
    logic [2:0]                     wr_left;
    logic                           wr_fail;
    logic [uts_pkg::ADDR_W-1:0]     wr_addr;
    logic [31:0]                    wr_data;
    logic                           lock_go;
    uts_pkg::uts_resp_t             resp;
    logic                           recal;
    logic [31:0]                    rdata;
  } uts_core_state_t;

  uts_core_state_t q;
  uts_core_state_t d;
  logic            accept;
  logic [7:0]      mem_byte;
  logic            mem_lock;
  logic            wr_lock;

  function automatic logic cmd_allowed(uts_pkg::uts_cmd_e c,
                                       uts_pkg::uts_state_t s);
    logic rdy;
    logic idf;
    logic dx;
    rdy = (s == uts_pkg::ST_READY);
    idf = (s == uts_pkg::ST_IDENTIFY);
    dx  = (s == uts_pkg::ST_DATA_EXCHANGE);
    case (c)
      uts_pkg::CMD_PICK_EQ, uts_pkg::CMD_PICK_NE, uts_pkg::CMD_PICK_GT,
      uts_pkg::CMD_PICK_LT, uts_pkg::CMD_PICK_EQF,
      uts_pkg::CMD_PICK_NEF:
        return rdy | idf;
      uts_pkg::CMD_DROP_EQ, uts_pkg::CMD_DROP_NE, uts_pkg::CMD_DROP_GT,
      uts_pkg::CMD_DROP_LT, uts_pkg::CMD_DROP_EQF, uts_pkg::CMD_DROP_NEF,
      uts_pkg::CMD_MULTI_DROP, uts_pkg::CMD_FAIL, uts_pkg::CMD_SUCCESS,
      uts_pkg::CMD_REPEAT, uts_pkg::CMD_FAIL_ALT,
      uts_pkg::CMD_SUCCESS_ALT, uts_pkg::CMD_REPEAT_ALT:
        return idf;
      uts_pkg::CMD_PROTECT:
        return dx;
      uts_pkg::CMD_DATA_READ, uts_pkg::CMD_DREAD_ALT,
      uts_pkg::CMD_QUAD_MULTI, uts_pkg::CMD_STORE_MULTI:
        return idf | dx;
      uts_pkg::CMD_REINIT, uts_pkg::CMD_READ, uts_pkg::CMD_READ_VFY,
      uts_pkg::CMD_READ_VFY4, uts_pkg::CMD_STORE, uts_pkg::CMD_QUAD_STORE,
      uts_pkg::CMD_PROTECT_QRY, uts_pkg::CMD_FLAG_READ,
      uts_pkg::CMD_VAR_READ, uts_pkg::CMD_PORT_READ,
      uts_pkg::CMD_ANON_FETCH:
        return rdy | idf | dx;
      default:
        return 1'b0;
    endcase
  endfunction

  function automatic logic is_store(uts_pkg::uts_cmd_e c);
    return c == uts_pkg::CMD_STORE || c == uts_pkg::CMD_QUAD_STORE ||
           c == uts_pkg::CMD_QUAD_MULTI || c == uts_pkg::CMD_STORE_MULTI;
  endfunction

  function automatic logic [7:0] flag_byte(uts_core_state_t s);
    logic [7:0] f;
    f = 8'h00;
    f[uts_pkg::FLAG_XCHG]  = s.xchg;
    f[uts_pkg::FLAG_WROK]  = s.wr_ok;
    f[uts_pkg::FLAG_BPRES] = BATTERY_FITTED;
    f[uts_pkg::FLAG_BGOOD] = s.bgood;
    return f;
  endfunction

  // a command acts only when whole, powered, settled and legal here
  assign accept = cmd.valid && cmd.crc_ok
               && q.st != uts_pkg::ST_POWER_OFF
               && !q.wait_resync
               && q.wr_left == 3'h0
               && cmd_allowed(cmd.code, q.st);

  uts_mem #(
    .AW    (uts_pkg::ADDR_W),
    .BYTES (uts_pkg::MEM_BYTES)
  ) u_mem (
    .clk       (clk),
    .wr_en     (q.wr_left != 3'h0),
    .wr_addr   (q.wr_addr),
    .wr_data   (q.wr_data[31:24]),
    .lock_en   (q.lock_go),
    .clr_locks (q.clr_locks),
    .rd_addr   (cmd.addr),
    .rd_data   (mem_byte),
    .rd_lock   (mem_lock),
    .wr_lock   (wr_lock)
  );

  always_comb begin
    d = q;
    d.resp.valid = 1'b0;
    d.recal = 1'b0;
    d.clr_locks = 1'b0;
    d.lock_go = 1'b0;
    d.rdata = 32'h0000_0000;
    d.bgood = BATTERY_FITTED & battery_good & energy_ok;
    // register port
    if (bus.rd) begin
      case (bus.addr)
        uts_pkg::REG_FLAGS: d.rdata = {24'h00_0000, flag_byte(q)};
        uts_pkg::REG_STATE: d.rdata = {30'h0000_0000, q.st};
        uts_pkg::REG_CTRL:  d.rdata = {31'h0000_0000, q.sealed};
        default:            d.rdata = 32'h0000_0000;
      endcase
    end
    if (bus.wr && bus.addr == uts_pkg::REG_CTRL) begin
      if (bus.wdata[uts_pkg::CTRL_SEALED_BIT]) begin
        d.sealed = 1'b1;
      end
      d.clr_locks = bus.wdata[uts_pkg::CTRL_CLRLOCK_BIT] & ~q.sealed;
    end
    // resync pattern restarts data recovery
    if (resync_seen) begin
      d.recal = 1'b1;
      d.wait_resync = 1'b0;
    end
    // multi-byte store, one byte per cycle, msbyte first
    if (q.wr_left != 3'h0) begin
      d.wr_fail = q.wr_fail | wr_lock;
      d.wr_addr = q.wr_addr + 8'h01;
      d.wr_data = {q.wr_data[23:0], 8'h00};
      d.wr_left = q.wr_left - 3'h1;
      if (q.wr_left == 3'h1) begin
        d.wr_ok = ~(q.wr_fail | wr_lock);
        d.wait_resync = 1'b1;
      end
    end
    if (accept) begin
      d.wr_ok = 1'b0;
      d.resp.valid = 1'b1;
      d.resp.data = mem_byte;
      case (cmd.code)
        uts_pkg::CMD_PICK_EQ, uts_pkg::CMD_PICK_NE, uts_pkg::CMD_PICK_GT,
        uts_pkg::CMD_PICK_LT, uts_pkg::CMD_PICK_EQF,
        uts_pkg::CMD_PICK_NEF: begin
          d.resp.valid = cmd.cond_match;
          if (cmd.cond_match) begin
            d.st = uts_pkg::ST_IDENTIFY;
          end
        end
        uts_pkg::CMD_DROP_EQ, uts_pkg::CMD_DROP_NE, uts_pkg::CMD_DROP_GT,
        uts_pkg::CMD_DROP_LT, uts_pkg::CMD_DROP_EQF,
        uts_pkg::CMD_DROP_NEF: begin
          d.resp.valid = ~cmd.cond_match;
          if (cmd.cond_match) begin
            d.st = uts_pkg::ST_READY;
          end
        end
        uts_pkg::CMD_MULTI_DROP: begin
          d.resp.valid = ~(cmd.cond_match & q.wr_ok);
          if (cmd.cond_match && q.wr_ok) begin
            d.st = uts_pkg::ST_READY;
          end
        end
        uts_pkg::CMD_REINIT: begin
          d.resp.valid = 1'b0;
          d.xchg = 1'b0;
          d.st = uts_pkg::ST_READY;
        end
        uts_pkg::CMD_FAIL, uts_pkg::CMD_SUCCESS, uts_pkg::CMD_REPEAT,
        uts_pkg::CMD_FAIL_ALT, uts_pkg::CMD_SUCCESS_ALT,
        uts_pkg::CMD_REPEAT_ALT: begin
          d.resp.data = flag_byte(q);
        end
        uts_pkg::CMD_ANON_FETCH: begin
          d.st = uts_pkg::ST_DATA_EXCHANGE;
        end
        uts_pkg::CMD_READ_VFY, uts_pkg::CMD_READ_VFY4: begin
          d.resp.valid = cmd.uid_match & q.wr_ok;
          if (cmd.uid_match && q.wr_ok) begin
            d.st = uts_pkg::ST_DATA_EXCHANGE;
          end
        end
        uts_pkg::CMD_PROTECT: begin
          d.resp.valid = cmd.uid_match;
          if (cmd.uid_match) begin
            d.wr_addr = cmd.addr;
            d.lock_go = 1'b1;
            d.wr_ok = 1'b1;
            d.wait_resync = 1'b1;
          end
        end
        uts_pkg::CMD_QUAD_MULTI, uts_pkg::CMD_STORE_MULTI: begin
          d.resp.valid = 1'b0;
          d.wr_addr = cmd.addr;
          d.wr_data = cmd.data;
          d.wr_fail = 1'b0;
          d.wr_left = cmd.code == uts_pkg::CMD_QUAD_MULTI ? QUAD : 3'h1;
        end
        default: begin
          // addressed reads, stores and queries
          d.resp.valid = cmd.uid_match;
          if (cmd.uid_match) begin
            d.st = uts_pkg::ST_DATA_EXCHANGE;
            if (cmd.code == uts_pkg::CMD_FLAG_READ) begin
              d.resp.data = flag_byte(q);
            end
            if (cmd.code == uts_pkg::CMD_PROTECT_QRY) begin
              d.resp.data = {7'h00, mem_lock};
            end
            if (is_store(cmd.code)) begin
              d.wr_addr = cmd.addr;
              d.wr_data = cmd.data;
              d.wr_fail = 1'b0;
              d.wr_left = cmd.code == uts_pkg::CMD_QUAD_STORE ? QUAD
                                                               : 3'h1;
            end
          end
        end
      endcase
    end
    if (d.st == uts_pkg::ST_DATA_EXCHANGE) begin
      d.xchg = 1'b1;
    end
    // power sequencing overrides the state, pending store, resync wait and response
    if (!energy_ok) begin
      d.st = uts_pkg::ST_POWER_OFF;
      d.wr_left = 3'h0;
      d.wait_resync = 1'b0;
      d.resp.valid = 1'b0;
    end else if (q.st == uts_pkg::ST_POWER_OFF && field_on) begin
      d.st = uts_pkg::ST_READY;
    end
    // retention timer runs only while powered off
    d.ret_cnt = '0;
    if (q.st == uts_pkg::ST_POWER_OFF && q.xchg) begin
      d.ret_cnt = q.ret_cnt + 1'b1;
      if (q.ret_cnt == RET_LAST) begin
        d.xchg = 1'b0;
        d.ret_cnt = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= uts_pkg::ST_POWER_OFF;
    end else begin
      q <= d;
    end
  end

  assign rdata        = q.rdata;
  assign resp         = q.resp;
  assign calib_reinit = q.recal;
  assign flags        = flag_byte(q);
  assign state        = q.st;

  sequence s_store_taken;
    accept && cmd.uid_match && cmd.code == uts_pkg::CMD_STORE;
  endsequence
  sequence s_store_done;
    ##1 q.wait_resync;
  endsequence

  a_ignore_illegal: assert property (@(posedge clk) disable iff (!reset_n)
    cmd.valid && !cmd_allowed(cmd.code, q.st) && energy_ok
    && q.st != uts_pkg::ST_POWER_OFF
    |=> !q.resp.valid && $stable(q.st))
    else $error("illegal command changed state or answered");
  a_crc_drop: assert property (@(posedge clk) disable iff (!reset_n)
    cmd.valid && !cmd.crc_ok && energy_ok |=> !q.resp.valid)
    else $error("bad crc frame was answered");
  a_resp_cause: assert property (@(posedge clk) disable iff (!reset_n)
    q.resp.valid |-> $past(accept))
    else $error("response without accepted command");
  a_xchg_held: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == uts_pkg::ST_DATA_EXCHANGE |-> q.xchg)
    else $error("exchange flag low in data exchange");
  a_reinit_clear: assert property (@(posedge clk) disable iff (!reset_n)
    accept && cmd.code == uts_pkg::CMD_REINIT && energy_ok
    |=> !q.xchg && q.st == uts_pkg::ST_READY)
    else $error("reinitialise left exchange flag or state");
  a_retain_time: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $fell(q.xchg) && $past(q.st) == uts_pkg::ST_POWER_OFF
    |-> $past(q.ret_cnt) == RET_LAST)
    else $error("exchange flag cleared early while off");
  a_power_loss: assert property (@(posedge clk) disable iff (!reset_n)
    !energy_ok |=> q.st == uts_pkg::ST_POWER_OFF)
    else $error("state kept after energy loss");
  a_power_up: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == uts_pkg::ST_POWER_OFF && energy_ok && field_on
    |=> q.st == uts_pkg::ST_READY)
    else $error("no move to ready on power up");
  a_wrok_clear: assert property (@(posedge clk) disable iff (!reset_n)
    accept && !is_store(cmd.code) && cmd.code != uts_pkg::CMD_PROTECT
    |=> !q.wr_ok)
    else $error("write ok survived following command");
  a_store_wait: assert property (@(posedge clk) disable iff (!reset_n)
    s_store_taken ##0 energy_ok ##1 energy_ok |-> s_store_done)
    else $error("store not followed by resync wait");
  a_flags_rfu: assert property (@(posedge clk) disable iff (!reset_n)
    flags[7:4] == 4'h0 && (BATTERY_FITTED || !flags[3]))
    else $error("reserved or battery flag bits wrong");
  a_seal_locks: assert property (@(posedge clk) disable iff (!reset_n)
    q.sealed |=> !q.clr_locks)
    else $error("lock clear after sealing");
endmodule
`default_nettype wire

// >>> rtl/uts_mem.sv
// byte memory with one sticky lock bit per byte
`default_nettype none
module uts_mem #(
  parameter int unsigned AW    = 8,
  parameter int unsigned BYTES = 256
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic          lock_en,
  input  wire logic          clr_locks,
  input  wire logic [AW-1:0] rd_addr,
  output logic [7:0]         rd_data,
  output logic               rd_lock,
  output logic               wr_lock
);
  // contents and locks are non-volatile: no reset on purpose
  typedef struct packed {
    logic [BYTES-1:0][7:0] mem;
    logic [BYTES-1:0]      lock;
  } uts_mem_state_t;

  uts_mem_state_t q;
  uts_mem_state_t d;

  always_comb begin
    d = q;
    if (clr_locks) begin
      d.lock = '0;
    end
    if (wr_en && !q.lock[wr_addr]) begin
      d.mem[wr_addr] = wr_data;
    end
    if (lock_en) begin
      d.lock[wr_addr] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign rd_data = q.mem[rd_addr];
  assign rd_lock = q.lock[rd_addr];
  assign wr_lock = q.lock[wr_addr];
endmodule
`default_nettype wire
